// *** rtl/pmi_pkg.sv ***
// Shared constants and types for the power-management serial register port
package pmi_pkg;

  // Bus address bytes
  localparam logic [7:0] DEV_WR_BYTE = 8'h50;
  localparam logic [7:0] DEV_RD_BYTE = 8'h51;

  // Register pointers
  localparam logic [7:0] A_DEVICE_ID   = 8'h00;
  localparam logic [7:0] A_SILICON_REV = 8'h01;
  localparam logic [7:0] A_SW_COMMON   = 8'h02;
  localparam logic [7:0] A_RESERVED    = 8'h03;
  localparam logic [7:0] A_RAIL1_VSET  = 8'h04;
  localparam logic [7:0] A_RAIL1_CFG   = 8'h05;
  localparam logic [7:0] A_RAIL2_VSET  = 8'h06;
  localparam logic [7:0] A_RAIL2_CFG   = 8'h07;
  localparam logic [7:0] A_LR1_VSET    = 8'h08;
  localparam logic [7:0] A_LR1_CFG     = 8'h09;
  localparam logic [7:0] A_LR2_VSET    = 8'h0a;
  localparam logic [7:0] A_LR2_CFG     = 8'h0b;
  localparam logic [7:0] A_MON_MUX     = 8'h0c;
  localparam logic [7:0] A_AUX_OUT     = 8'h0d;
  localparam logic [7:0] A_PWR_CMD     = 8'h0e;
  localparam logic [7:0] A_STATUS      = 8'h0f;
  localparam logic [7:0] A_PWR_CFG     = 8'h10;
  localparam logic [7:0] A_SW_SEQ      = 8'h11;
  localparam logic [7:0] A_LR_SEQ      = 8'h12;
  localparam logic [7:0] A_LAST        = A_LR_SEQ;
  localparam int         NUM_REGS      = 19;

  // Implemented bits per pointer; writable ones carry a nonzero write mask
  localparam logic [NUM_REGS-1:0][7:0] WR_MASK = {
    8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hc3, 8'h0f, 8'hf1, 8'h3f, 8'hf1,
    8'h3f, 8'hf8, 8'h3f, 8'hf8, 8'h3f, 8'h00, 8'h8f, 8'h00, 8'h00};
  localparam logic [NUM_REGS-1:0][7:0] RD_MASK = {
    8'h77, 8'h77, 8'he3, 8'hff, 8'hff, 8'hc3, 8'h0f, 8'hf1, 8'h3f, 8'hf1,
    8'h3f, 8'hf8, 8'h3f, 8'hf8, 8'h3f, 8'h00, 8'h8f, 8'hff, 8'hff};
  localparam logic [7:0] REG_RESET = 8'h00;

  // Fastest serial clock served
  localparam int SCL_MAX_KHZ = 400;

  // Bit count of the last bit in a byte, counted from zero
  localparam logic [2:0] BYTE_LAST_BIT = 3'h7;

  typedef enum logic [4:0] {
    L_IDLE = 5'h01,
    L_RX   = 5'h02,
    L_ACK  = 5'h04,
    L_TX   = 5'h08,
    L_RACK = 5'h10
  } pmi_lst_t;

  typedef enum logic [2:0] {
    K_ADDR = 3'h1,
    K_PTR  = 3'h2,
    K_DATA = 3'h4
  } pmi_kind_t;

  typedef struct packed {
    logic [1:0] scl_sy;
    logic [1:0] sda_sy;
    logic       scl_p;
    logic       sda_p;
    pmi_lst_t   st;
    pmi_kind_t  kind;
    logic [2:0] cnt;
    logic       full;
    logic [7:0] sh;
    logic       rw;
    logic       nak;
    logic       mack;
    logic [7:0] ptr;
    logic       sda_oe;
    logic       req;
    logic       req_wr;
    logic [7:0] req_waddr;
    logic [7:0] req_wdata;
    logic [7:0] req_raddr;
    logic [1:0] ack_sy;
    logic       ack_p;
    logic [7:0] rbuf;
  } pmi_link_t;

  typedef struct packed {
    logic [1:0]                req_sy;
    logic                      req_p;
    logic                      ack;
    logic [7:0]                rdata;
    logic [1:0][7:0]           stat_sy;
    logic [NUM_REGS-1:0][7:0]  regs;
  } pmi_core_t;

endpackage

// *** rtl/pmi_i2c_port.sv ***
// Serial register port: link-clock protocol engine and system-clock register file
// Operation
// - Serve serial clock up to 400kHz
// - Release data line while bus idle
// - Sample on rising edge, hold while high
// - Data change with clock high is control
// - First byte: address plus direction bit
// - Ack pointer only when register valid
// - Single write: ack and store data
// - Burst write advances pointer except zero
// - Burst write repeats data then stop
// - Single read via repeated start, eight bits
// - Burst read; release line after last
// - Ack: pull low through ninth clock
// - Nak: leave line high ninth clock
// - Answer only address bytes 0x50, 0x51
`timescale 1ns/100ps

module pmi_i2c_port #(
  parameter logic [7:0] DEVICE_ID = 8'h5a,  // Arbitrary value
  parameter logic [7:0] SI_REV    = 8'h01,  // Arbitrary value
  parameter logic [7:0] PWR_CFG   = 8'h00,
  parameter logic [7:0] SW_SEQ    = 8'h00,
  parameter logic [7:0] LR_SEQ    = 8'h00
) (
  input  wire logic       CLK,
  input  wire logic       RSTN,
  input  wire logic       LINK_CLK,
  input  wire logic       SCL_I,
  input  wire logic       SDA_I,
  output logic            SDA_O,
  output logic            SDA_OE,
  input  wire logic [7:0] STATUS_IN,
  output logic [7:0]      SW_COMMON_CFG,
  output logic [7:0]      RAIL1_VSET,
  output logic [7:0]      RAIL1_CFG,
  output logic [7:0]      RAIL2_VSET,
  output logic [7:0]      RAIL2_CFG,
  output logic [7:0]      LINREG1_VSET,
  output logic [7:0]      LINREG1_CFG,
  output logic [7:0]      LINREG2_VSET,
  output logic [7:0]      LINREG2_CFG,
  output logic [7:0]      MON_MUX_CFG,
  output logic [7:0]      AUX_OUT_CFG,
  output logic [7:0]      PWR_COMMAND
);

  // Factory values must fit their implemented bits
  if ((PWR_CFG & ~pmi_pkg::RD_MASK[pmi_pkg::A_PWR_CFG]) != 8'h00) begin : g_chk_pc
    $error("power config parameter sets unused bits");
  end
  if ((SW_SEQ & ~pmi_pkg::RD_MASK[pmi_pkg::A_SW_SEQ]) != 8'h00) begin : g_chk_ss
    $error("switcher sequence parameter sets unused bits");
  end
  if ((LR_SEQ & ~pmi_pkg::RD_MASK[pmi_pkg::A_LR_SEQ]) != 8'h00) begin : g_chk_ls
    $error("linreg sequence parameter sets unused bits");
  end

  // Register file is indexed by the low five pointer bits
  if ((pmi_pkg::NUM_REGS != int'(pmi_pkg::A_LAST) + 1) || (pmi_pkg::NUM_REGS > 32)) begin : g_chk_map
    $error("register count does not match the pointer range");
  end

  // A writable bit that did not read back would be invisible to the host
  for (genvar i = 0; i < pmi_pkg::NUM_REGS; i++) begin : g_chk_mask
    if ((pmi_pkg::WR_MASK[i] & ~pmi_pkg::RD_MASK[i]) != 8'h00) begin : g_bad
      $error("write mask exceeds readable bits");
    end
  end

  pmi_pkg::pmi_link_t l_q;
  pmi_pkg::pmi_link_t l_d;
  pmi_pkg::pmi_core_t c_q;
  pmi_pkg::pmi_core_t c_d;

  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  function automatic logic ptr_valid(input logic [7:0] p);
    ptr_valid = (p <= pmi_pkg::A_LAST) && (p != pmi_pkg::A_RESERVED);
  endfunction

  // Pointer zero stays put, any other pointer moves on
  function automatic logic [7:0] ptr_next(input logic [7:0] p);
    ptr_next = (p == pmi_pkg::A_DEVICE_ID) ? p : 8'(p + 8'h01);
  endfunction

  // Hand a write and/or read-ahead to the register file if the crossing is free
  function automatic pmi_pkg::pmi_link_t issue(input pmi_pkg::pmi_link_t s,
                                               input logic              wr,
                                               input logic [7:0]        wa,
                                               input logic [7:0]        wd,
                                               input logic [7:0]        ra);
    pmi_pkg::pmi_link_t r;
    r = s;
    if (s.req == s.ack_sy[1]) begin
      r.req       = ~s.req;
      r.req_wr    = wr;
      r.req_waddr = wa;
      r.req_wdata = wd;
      r.req_raddr = ra;
    end
    issue = r;
  endfunction

  // Link side: pins pass two flops, events follow from the second flop only
  assign scl_s     = l_q.scl_sy[1];
  assign sda_s     = l_q.sda_sy[1];
  assign scl_rise  = scl_s & ~l_q.scl_p;
  assign scl_fall  = ~scl_s & l_q.scl_p;
  assign bus_start = scl_s & l_q.scl_p & l_q.sda_p & ~sda_s;
  assign bus_stop  = scl_s & l_q.scl_p & ~l_q.sda_p & sda_s;

  always_comb begin
    l_d        = l_q;
    l_d.scl_sy = {l_q.scl_sy[0], SCL_I};
    l_d.sda_sy = {l_q.sda_sy[0], SDA_I};
    l_d.ack_sy = {l_q.ack_sy[0], c_q.ack};
    l_d.scl_p  = scl_s;
    l_d.sda_p  = sda_s;
    // Read data is stable once the returned toggle has settled
    if (l_q.ack_sy[1] != l_q.ack_p) begin
      l_d.ack_p = l_q.ack_sy[1];
      l_d.rbuf  = c_q.rdata;
    end
    if (bus_start) begin
      // Start and repeated start both restart address reception
      l_d.st     = pmi_pkg::L_RX;
      l_d.kind   = pmi_pkg::K_ADDR;
      l_d.cnt    = 3'h0;
      l_d.full   = 1'b0;
      l_d.sda_oe = 1'b0;
    end else if (bus_stop) begin
      l_d.st     = pmi_pkg::L_IDLE;
      l_d.sda_oe = 1'b0;
    end else begin
      case (l_q.st)
        pmi_pkg::L_IDLE: begin
          l_d.sda_oe = 1'b0;
        end
        pmi_pkg::L_RX: begin
          if (scl_rise) begin
            l_d.sh  = {l_q.sh[6:0], sda_s};
            l_d.cnt = 3'(l_q.cnt + 3'h1);
            if (l_q.cnt == pmi_pkg::BYTE_LAST_BIT) begin
              l_d.full = 1'b1;
            end
          end else if (scl_fall && l_q.full) begin
            l_d.full = 1'b0;
            l_d.nak  = 1'b0;
            l_d.st   = pmi_pkg::L_ACK;
            case (l_q.kind)
              pmi_pkg::K_ADDR: begin
                if (l_q.sh == pmi_pkg::DEV_WR_BYTE) begin
                  l_d.rw   = 1'b0;
                  l_d.kind = pmi_pkg::K_PTR;
                end else if (l_q.sh == pmi_pkg::DEV_RD_BYTE) begin
                  l_d.rw = 1'b1;
                end else begin
                  l_d.st = pmi_pkg::L_IDLE;
                end
              end
              pmi_pkg::K_PTR: begin
                if (ptr_valid(l_q.sh)) begin
                  l_d.ptr  = l_q.sh;
                  l_d.kind = pmi_pkg::K_DATA;
                  l_d      = issue(l_d, 1'b0, l_q.sh, 8'h00, l_q.sh);
                end else begin
                  l_d.nak = 1'b1;
                end
              end
              default: begin
                // Store the byte and read ahead at the advanced pointer
                l_d     = issue(l_d, 1'b1, l_q.ptr, l_q.sh, ptr_next(l_q.ptr));
                l_d.ptr = ptr_next(l_q.ptr);
              end
            endcase
            if ((l_d.st == pmi_pkg::L_ACK) && !l_d.nak) begin
              l_d.sda_oe = 1'b1;
            end
          end
        end
        pmi_pkg::L_ACK: begin
          // Low level or release stands through the ninth clock high time
          if (scl_fall) begin
            l_d.sda_oe = 1'b0;
            l_d.cnt    = 3'h0;
            if (l_q.nak) begin
              l_d.st = pmi_pkg::L_IDLE;
            end else if (l_q.rw) begin
              l_d.st     = pmi_pkg::L_TX;
              l_d.sh     = l_q.rbuf;
              l_d.sda_oe = ~l_q.rbuf[7];
            end else begin
              l_d.st = pmi_pkg::L_RX;
            end
          end
        end
        pmi_pkg::L_TX: begin
          if (scl_rise) begin
            l_d.cnt = 3'(l_q.cnt + 3'h1);
            if (l_q.cnt == pmi_pkg::BYTE_LAST_BIT) begin
              l_d.full = 1'b1;
            end
          end else if (scl_fall) begin
            if (l_q.full) begin
              // Free the line for the master's answer, fetch the next byte
              l_d.full   = 1'b0;
              l_d.st     = pmi_pkg::L_RACK;
              l_d.sda_oe = 1'b0;
              l_d.ptr    = ptr_next(l_q.ptr);
              l_d        = issue(l_d, 1'b0, l_q.ptr, 8'h00, ptr_next(l_q.ptr));
            end else begin
              // Bit changes only while the clock is low
              l_d.sh     = {l_q.sh[6:0], 1'b0};
              l_d.sda_oe = ~l_q.sh[6];
            end
          end
        end
        pmi_pkg::L_RACK: begin
          if (scl_rise) begin
            l_d.mack = ~sda_s;
          end else if (scl_fall) begin
            l_d.cnt = 3'h0;
            if (l_q.mack) begin
              l_d.st     = pmi_pkg::L_TX;
              l_d.sh     = l_q.rbuf;
              l_d.sda_oe = ~l_q.rbuf[7];
            end else begin
              l_d.st     = pmi_pkg::L_IDLE;
              l_d.sda_oe = 1'b0;
            end
          end
        end
        default: begin
          l_d.st     = pmi_pkg::L_IDLE;
          l_d.sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge LINK_CLK or negedge RSTN) begin
    if (!RSTN) begin
      l_q           <= '0;
      l_q.scl_sy    <= 2'h3;
      l_q.sda_sy    <= 2'h3;
      l_q.scl_p     <= 1'b1;
      l_q.sda_p     <= 1'b1;
      l_q.st        <= pmi_pkg::L_IDLE;
      l_q.kind      <= pmi_pkg::K_ADDR;
    end else begin
      l_q <= l_d;
    end
  end

  // Open drain: only ever pulls low
  assign SDA_O  = 1'b0;
  assign SDA_OE = l_q.sda_oe;

  // System side: register file answering one request per toggle
  function automatic logic [7:0] reg_read(input logic [7:0]                        a,
                                          input logic [pmi_pkg::NUM_REGS-1:0][7:0] r,
                                          input logic [7:0]                        st);
    logic [7:0] v;
    v = 8'h00;
    if (!ptr_valid(a)) begin
      v = 8'h00;
    end else if (a == pmi_pkg::A_DEVICE_ID) begin
      v = DEVICE_ID;
    end else if (a == pmi_pkg::A_SILICON_REV) begin
      v = SI_REV;
    end else if (a == pmi_pkg::A_STATUS) begin
      v = st;
    end else if (a == pmi_pkg::A_PWR_CFG) begin
      v = PWR_CFG;
    end else if (a == pmi_pkg::A_SW_SEQ) begin
      v = SW_SEQ;
    end else if (a == pmi_pkg::A_LR_SEQ) begin
      v = LR_SEQ;
    end else begin
      v = r[a[4:0]];
    end
    reg_read = ptr_valid(a) ? (v & pmi_pkg::RD_MASK[a[4:0]]) : 8'h00;
  endfunction

  always_comb begin
    c_d         = c_q;
    c_d.req_sy  = {c_q.req_sy[0], l_q.req};
    c_d.stat_sy = {c_q.stat_sy[0], STATUS_IN};
    // Request fields are read only once the toggle has crossed, so they are settled
    if (c_q.req_sy[1] != c_q.req_p) begin
      c_d.req_p = c_q.req_sy[1];
      // Read-only and unmapped pointers take the write without effect
      if (l_q.req_wr && ptr_valid(l_q.req_waddr)) begin
        c_d.regs[l_q.req_waddr[4:0]] =
          (c_q.regs[l_q.req_waddr[4:0]] & ~pmi_pkg::WR_MASK[l_q.req_waddr[4:0]]) |
          (l_q.req_wdata & pmi_pkg::WR_MASK[l_q.req_waddr[4:0]]);
      end
      c_d.rdata = reg_read(l_q.req_raddr, c_d.regs, c_q.stat_sy[1]);
      c_d.ack   = c_q.req_sy[1];
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      c_q      <= '0;
      c_q.regs <= {pmi_pkg::NUM_REGS{pmi_pkg::REG_RESET}};
    end else begin
      c_q <= c_d;
    end
  end

  assign SW_COMMON_CFG = c_q.regs[pmi_pkg::A_SW_COMMON[4:0]];
  assign RAIL1_VSET    = c_q.regs[pmi_pkg::A_RAIL1_VSET[4:0]];
  assign RAIL1_CFG     = c_q.regs[pmi_pkg::A_RAIL1_CFG[4:0]];
  assign RAIL2_VSET    = c_q.regs[pmi_pkg::A_RAIL2_VSET[4:0]];
  assign RAIL2_CFG     = c_q.regs[pmi_pkg::A_RAIL2_CFG[4:0]];
  assign LINREG1_VSET  = c_q.regs[pmi_pkg::A_LR1_VSET[4:0]];
  assign LINREG1_CFG   = c_q.regs[pmi_pkg::A_LR1_CFG[4:0]];
  assign LINREG2_VSET  = c_q.regs[pmi_pkg::A_LR2_VSET[4:0]];
  assign LINREG2_CFG   = c_q.regs[pmi_pkg::A_LR2_CFG[4:0]];
  assign MON_MUX_CFG   = c_q.regs[pmi_pkg::A_MON_MUX[4:0]];
  assign AUX_OUT_CFG   = c_q.regs[pmi_pkg::A_AUX_OUT[4:0]];
  assign PWR_COMMAND   = c_q.regs[pmi_pkg::A_PWR_CMD[4:0]];

endmodule // pmi_i2c_port

// *** dv/pmi_i2c_port_sva.sv ***
// Checker for the serial register port, bound to its top module
`timescale 1ns/100ps

module pmi_i2c_port_sva (
  input wire logic       CLK,
  input wire logic       RSTN,
  input wire logic       LINK_CLK,
  input wire logic       SCL_I,
  input wire logic       SDA_I,
  input wire logic       SDA_O,
  input wire logic       SDA_OE,
  input wire logic [7:0] SW_COMMON_CFG,
  input wire logic [7:0] RAIL1_VSET,
  input wire logic [7:0] MON_MUX_CFG,
  input wire logic [7:0] AUX_OUT_CFG
);
  logic       scl_q, sda_q, ok_q, act_q;
  logic [3:0] bit_q;
  logic [1:0] byte_q;
  logic [7:0] sh_q, adr_q;
  wire rise  = !scl_q && SCL_I;
  wire start = scl_q && SCL_I && sda_q && !SDA_I;
  wire stop  = scl_q && SCL_I && !sda_q && SDA_I;
  wire valid = sh_q <= pmi_pkg::A_LAST && sh_q != pmi_pkg::A_RESERVED;

  // Bit and byte position on the raw pins since the last START
  always_ff @(posedge LINK_CLK or negedge RSTN) begin
    if (!RSTN) begin
      scl_q  <= 1'b1;
      sda_q  <= 1'b1;
      ok_q   <= 1'b0;
      act_q  <= 1'b0;
      bit_q  <= 4'h0;
      byte_q <= 2'h0;
      sh_q   <= 8'h00;
      adr_q  <= 8'h00;
    end else begin
      scl_q <= SCL_I;
      sda_q <= SDA_I;
      if (stop) begin
        act_q <= 1'b0;
      end
      if (start) begin
        act_q  <= 1'b1;
        bit_q  <= 4'h0;
        byte_q <= 2'h0;
      end else if (rise && bit_q == 4'h8) begin
        bit_q  <= 4'h0;
        byte_q <= (byte_q == 2'h2) ? 2'h2 : byte_q + 2'h1;
        if (byte_q == 2'h0) adr_q <= sh_q;
        if (byte_q == 2'h1) ok_q <= valid;
      end else if (rise) begin
        bit_q <= bit_q + 4'h1;
        sh_q  <= {sh_q[6:0], SDA_I};
      end
    end
  end

  sequence s_ninth;
    rise && bit_q == 4'h8;
  endsequence

  a_pin_low_only: assert property (@(posedge LINK_CLK) disable iff (!RSTN)
    !act_q |-> (SDA_O == 1'b0 && !SDA_OE))
    else $error("data line pulled while bus idle");
  a_addr_ack: assert property (@(posedge LINK_CLK) disable iff (!RSTN) s_ninth ##0
    (byte_q == 2'h0 && (sh_q == pmi_pkg::DEV_WR_BYTE || sh_q == pmi_pkg::DEV_RD_BYTE)) |-> SDA_OE)
    else $error("own address not acknowledged");
  a_addr_ignore: assert property (@(posedge LINK_CLK) disable iff (!RSTN) s_ninth ##0
    (byte_q == 2'h0 && sh_q != pmi_pkg::DEV_WR_BYTE && sh_q != pmi_pkg::DEV_RD_BYTE) |-> !SDA_OE)
    else $error("foreign address acknowledged");
  a_ptr_ack: assert property (@(posedge LINK_CLK) disable iff (!RSTN) s_ninth ##0
    (byte_q == 2'h1 && adr_q == pmi_pkg::DEV_WR_BYTE) |-> SDA_OE == valid)
    else $error("pointer acknowledge wrong");
  a_data_ack: assert property (@(posedge LINK_CLK) disable iff (!RSTN) s_ninth ##0
    (byte_q == 2'h2 && adr_q == pmi_pkg::DEV_WR_BYTE && ok_q) |-> SDA_OE)
    else $error("data byte not acknowledged");
  a_read_release: assert property (@(posedge LINK_CLK) disable iff (!RSTN) s_ninth ##0
    (byte_q != 2'h0 && adr_q == pmi_pkg::DEV_RD_BYTE) |-> !SDA_OE)
    else $error("data line held during master acknowledge");
  a_hold_high: assert property (@(posedge LINK_CLK) disable iff (!RSTN)
    (SCL_I && scl_q) |-> $stable(SDA_OE))
    else $error("data drive changed with clock high");
  a_idle_stop: assert property (@(posedge LINK_CLK) disable iff (!RSTN)
    stop |=> !SDA_OE [*8])
    else $error("data line pulled after stop");
  a_unused_zero: assert property (@(posedge CLK) disable iff (!RSTN)
    ((SW_COMMON_CFG & ~pmi_pkg::WR_MASK[2]) | (RAIL1_VSET & ~pmi_pkg::WR_MASK[4])
     | (MON_MUX_CFG & ~pmi_pkg::WR_MASK[12]) | (AUX_OUT_CFG & ~pmi_pkg::WR_MASK[13])) == 8'h00)
    else $error("unused register bit set");
endmodule // pmi_i2c_port_sva

bind pmi_i2c_port pmi_i2c_port_sva u_sva (.CLK, .RSTN, .LINK_CLK, .SCL_I, .SDA_I, .SDA_O, .SDA_OE,
  .SW_COMMON_CFG, .RAIL1_VSET, .MON_MUX_CFG, .AUX_OUT_CFG);

// *** dv/pmi_host.sv ***
// Bus master model: pulls the clock and data lines low, open drain
`timescale 1ns/100ps

module pmi_host (
  input  wire logic clk,
  input  wire logic sda_in,
  output logic      scl_pull,
  output logic      sda_pull
);
  localparam int Q = 13;  // Quarter bit: 385 kHz, clock low 1.3 us

  initial begin
    scl_pull = 1'b0;  // Both lines released while idle
    sda_pull = 1'b0;
  end

  task automatic qw();
    repeat (Q) @(negedge clk);
  endtask

  // Also serves as repeated START from mid-frame
  task automatic start();
    sda_pull = 1'b0;
    qw();
    scl_pull = 1'b0;
    qw();
    sda_pull = 1'b1;
    qw();
    scl_pull = 1'b1;
    qw();
  endtask

  task automatic stop();
    sda_pull = 1'b1;
    qw();
    scl_pull = 1'b0;
    qw();
    sda_pull = 1'b0;
    qw();
  endtask

  task automatic bitx(input logic b, output logic r);
    sda_pull = !b;
    qw();
    scl_pull = 1'b0;
    qw();
    r = sda_in;
    qw();
    scl_pull = 1'b1;
    qw();
  endtask

  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(b[i], r);
    bitx(1'b1, r);
    ack = !r;
  endtask

  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, r);
      d[i] = r;
    end
    bitx(last, r);  // Acknowledge all but the last byte
  endtask
endmodule // pmi_host

// *** dv/testbench.sv ***
// Self-checking bench for the serial register port
`timescale 1ns/100ps

module testbench;
  localparam logic [7:0] ID_CODE  = 8'h3c;  // Arbitrary value
  localparam logic [7:0] REV_CODE = 8'h2b;  // Arbitrary value
  localparam logic [7:0] FAC_PWR  = 8'ha2;
  localparam logic [7:0] FAC_SW   = 8'h53;
  localparam logic [7:0] FAC_LR   = 8'h25;
  logic             clk      = 1'b0;
  logic             link_clk = 1'b0;
  logic             rstn     = 1'b0;
  logic [7:0]       status   = 8'h00;
  logic             scl_pull, sda_pull, sda_oe;
  wire  [11:0][7:0] outs;
  logic [7:0]       regs [0:18];
  int               error_cnt = 0;
  int               checks    = 0;
  wire              scl = !scl_pull;
  wire              sda = !(sda_pull || sda_oe);

  pmi_i2c_port #(.DEVICE_ID(ID_CODE), .SI_REV(REV_CODE), .PWR_CFG(FAC_PWR), .SW_SEQ(FAC_SW),
                 .LR_SEQ(FAC_LR)) DUT (
    .CLK(clk), .RSTN(rstn), .LINK_CLK(link_clk), .SCL_I(scl), .SDA_I(sda), .SDA_O(),
    .SDA_OE(sda_oe), .STATUS_IN(status), .SW_COMMON_CFG(outs[0]), .RAIL1_VSET(outs[1]),
    .RAIL1_CFG(outs[2]), .RAIL2_VSET(outs[3]), .RAIL2_CFG(outs[4]), .LINREG1_VSET(outs[5]),
    .LINREG1_CFG(outs[6]), .LINREG2_VSET(outs[7]), .LINREG2_CFG(outs[8]),
    .MON_MUX_CFG(outs[9]), .AUX_OUT_CFG(outs[10]), .PWR_COMMAND(outs[11]));
  pmi_host host (.clk(clk), .sda_in(sda), .scl_pull(scl_pull), .sda_pull(sda_pull));

  always #25 clk = ~clk;
  initial begin
    #13;
    forever #62.5 link_clk = ~link_clk;
  end

  function automatic logic ok_ptr(logic [7:0] p);
    return p <= pmi_pkg::A_LAST && p != pmi_pkg::A_RESERVED;
  endfunction

  function automatic logic [7:0] ev(logic [7:0] p);
    if (p > pmi_pkg::A_LAST) return 8'h00;
    return (p == pmi_pkg::A_STATUS ? status : regs[p]) & pmi_pkg::RD_MASK[p];
  endfunction

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_ack(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t ack got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_outs();
    for (int i = 0; i < 12; i++) cmp_byte(outs[i], regs[i == 0 ? 2 : i + 3]);
  endtask

  task automatic wr(input logic [7:0] p, input logic [7:0] d [$]);
    logic a;
    host.start();
    host.wbyte(pmi_pkg::DEV_WR_BYTE, a);
    cmp_ack(a, 1'b1);
    host.wbyte(p, a);
    cmp_ack(a, ok_ptr(p));
    if (ok_ptr(p)) begin
      foreach (d[i]) begin
        host.wbyte(d[i], a);
        cmp_ack(a, 1'b1);
        if (p <= pmi_pkg::A_LAST && pmi_pkg::WR_MASK[p] != 8'h00) begin
          regs[p] = d[i] & pmi_pkg::WR_MASK[p];
        end
        if (p != 8'h00) p++;
      end
    end
    host.stop();
    repeat (20) @(negedge clk);
  endtask

  task automatic rd(input logic [7:0] p, input int n);
    logic       a;
    logic [7:0] v;
    status = 8'($urandom());
    host.start();
    host.wbyte(pmi_pkg::DEV_WR_BYTE, a);
    host.wbyte(p, a);
    cmp_ack(a, 1'b1);
    host.start();
    host.wbyte(pmi_pkg::DEV_RD_BYTE, a);
    cmp_ack(a, 1'b1);
    for (int i = 0; i < n; i++) begin
      host.rbyte(i == n - 1, v);
      cmp_byte(v, ev(p));
      if (p != 8'h00) p++;
    end
    host.stop();
    repeat (20) @(negedge clk);
  endtask

  task automatic results();
    if (error_cnt == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    logic [7:0] bad [3];
    logic [7:0] inv [3];
    logic [7:0] q [$];
    logic [7:0] p;
    logic       a;
    bad = '{8'h52, 8'ha1, 8'h10};
    inv = '{8'h03, 8'h13, 8'hff};
    void'($urandom(32'hb8d5cad7));
    foreach (regs[i]) regs[i] = 8'h00;
    regs[0] = ID_CODE;
    regs[1] = REV_CODE;
    regs[16] = FAC_PWR;
    regs[17] = FAC_SW;
    regs[18] = FAC_LR;
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    repeat (10) @(negedge clk);
    chk_outs();
    for (int i = 0; i < 3; i++) begin
      host.start();
      host.wbyte(bad[i], a);
      cmp_ack(a, 1'b0);
      host.stop();
      q = {8'h11};
      wr(inv[i], q);
    end
    // Pointers 0x02 to 0x12 in one burst, then pointer 0 pinned, then read back
    q = {};
    repeat (17) q.push_back(8'($urandom()));
    wr(8'h02, q);
    chk_outs();
    // A pointer that moved on would reach the first writable register
    q = {8'hff, 8'h00, 8'h5a};
    wr(8'h00, q);
    chk_outs();
    rd(8'h00, 3);
    rd(8'h01, 18);
    repeat (5) begin
      p = 8'($urandom_range(2, 16));
      if (p == pmi_pkg::A_RESERVED) p = 8'h04;
      q = {};
      repeat ($urandom_range(1, 3)) q.push_back(8'($urandom()));
      wr(p, q);
      chk_outs();
      rd(p, q.size());
    end
    results();
  end

  // Tests take about 50k clocks; this bound only cuts a hang short
  initial begin
    repeat (95000) @(posedge clk);
    error_cnt++;
    results();
  end
endmodule // testbench
